/* File: rtl/ofsr_pkg.sv */
// Package: constants for the output fault and status reporting bank
// Behaviour
// - Injector, relay and lamp fault registers hold summary in bit 7 and open-load, overcurrent, overtemp, short-ground in bits 3..0, bits 6..4 zero.
// - Ignition and heater fault registers hold only summary, open-load and overcurrent; tacho drops short-ground but keeps overtemp.
// - Off-state open load is checked only while the output is commanded off, one comparator per output.
// - Pull-down sources are on after power-up and open-load detection works only while the source is on.
// - A disabled pull-down source forces its open-load flag to read zero.
// - A pull-down source turns off only in sleep or when disabled over the serial interface.
// - Open-load reports pass a filter delay between 100 and 450 us.
// - Chip-select rising edge restarts the fault timer; the comparator is accepted only after it expires, and from one cycle after reset.
// - A detected fault stays latched until the microcontroller reads it, or for open load until its pull-down source turns off, even after the condition clears.
// - In the low supply band commands still execute though status is not guaranteed.
package ofsr_pkg;
    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [3:0] IDX_INJ_ONE = 4'h0;
    localparam logic [3:0] IDX_INJ_TWO = 4'h1;
    localparam logic [3:0] IDX_REL_ONE = 4'h2;
    localparam logic [3:0] IDX_REL_TWO = 4'h3;
    localparam logic [3:0] IDX_TACHO = 4'h4;
    localparam logic [3:0] IDX_LAMP = 4'h5;
    localparam logic [3:0] IDX_HEATER = 4'h7;
    localparam logic [3:0] IDX_SPARK_ONE = 4'h8;
    localparam logic [3:0] IDX_SPARK_TWO = 4'h9;
    localparam logic [3:0] IDX_WATCHDOG = 4'hA;
    localparam logic [3:0] IDX_SENSOR = 4'hB;
    localparam logic [3:0] IDX_SUPPLY = 4'hD;
    localparam logic [3:0] IDX_ON_OFF = 4'hE;
    localparam logic [3:0] IDX_MODEL = 4'hF;
    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int BIT_SUMMARY = 7;
    localparam int BIT_OPEN_LOAD = 3;
    localparam int BIT_OVERCURRENT = 2;
    localparam int BIT_OVERTEMP = 1;
    localparam int BIT_SHORT_GND = 0;
    localparam logic [3:0] MASK_FULL = 4'hF;
    localparam logic [3:0] MASK_TACHO = 4'hE;
    localparam logic [3:0] MASK_PRE = 4'hC;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Model and revision codes, arbitrary values
    localparam logic [2:0] MODEL_CODE = 3'h1;
    localparam logic [4:0] REV_CODE = 5'h01;
    // ****************************************************************
    // Outputs and timing
    // ****************************************************************
    localparam int NUM_OUT = 9;
    localparam int CLK_MHZ = 250;
    localparam int FILT_MIN_US = 100;
    localparam int FILT_MAX_US = 450;
    localparam int FILT_CYCLES = ((FILT_MIN_US + FILT_MAX_US) / 2) * CLK_MHZ;
    localparam int TMR_W = 17;
    // Output order: injector_one injector_two relay_one relay_two tacho lamp heater spark1 spark2
    typedef enum logic [2:0] {
        OFSR_IDLE_T = 3'b001,
        OFSR_WAIT_T = 3'b010,
        OFSR_ARMED_T = 3'b100
    } ofsr_tmr_t;
endpackage

/* File: rtl/ofsr_bank.sv */
// Module: output fault and status register bank
`timescale 1ns/1ps
module ofsr_bank
    import ofsr_pkg::*;
#(
    parameter int FILT_CNT = FILT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Serial frame
    input wire logic chip_select_n,
    input wire logic rd_strobe,
    input wire logic [3:0] rd_index,
    output logic [7:0] rd_data,
    // Output commands and pull-down control
    input wire logic [NUM_OUT-1:0] out_cmd_on,
    input wire logic [NUM_OUT-1:0] pulldown_dis,
    input wire logic sleep_mode,
    input wire logic self_test_wr,
    input wire logic self_test_val,
    output logic self_test_enable,
    output logic [NUM_OUT-1:0] pulldown_on,
    // Analog fault comparators
    input wire logic [NUM_OUT-1:0] open_load_cmp,
    input wire logic [NUM_OUT-1:0] overcurrent_in,
    input wire logic [NUM_OUT-1:0] overtemp_in,
    input wire logic [NUM_OUT-1:0] short_ground_in,
    // Other status sources
    input wire logic [7:0] watchdog_in,
    input wire logic [7:0] sensor_in,
    input wire logic [7:0] supply_in,
    input wire logic [7:0] on_off_in
);
    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    logic [NUM_OUT-1:0] ol_s1_q, ol_s2_q;
    logic [NUM_OUT-1:0] oc_s1_q, oc_s2_q;
    logic [NUM_OUT-1:0] ot_s1_q, ot_s2_q;
    logic [NUM_OUT-1:0] sg_s1_q, sg_s2_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    always_ff @(posedge core_clk) begin
        ol_s1_q <= open_load_cmp;
        ol_s2_q <= ol_s1_q;
        oc_s1_q <= overcurrent_in;
        oc_s2_q <= oc_s1_q;
        ot_s1_q <= overtemp_in;
        ot_s2_q <= ot_s1_q;
        sg_s1_q <= short_ground_in;
        sg_s2_q <= sg_s1_q;
        cs_s1_q <= chip_select_n;
        cs_s2_q <= cs_s1_q;
        cs_s3_q <= cs_s2_q;
    end
    wire cs_rise = cs_s2_q & ~cs_s3_q;
    // ****************************************************************
    // Fault filter timer
    // ****************************************************************
    ofsr_tmr_t tmr_q, tmr_d;
    logic [TMR_W-1:0] cnt_q, cnt_d;
    always_comb begin
        tmr_d = tmr_q;
        cnt_d = cnt_q;
        case (tmr_q)
            OFSR_IDLE_T: begin
                tmr_d = OFSR_ARMED_T;
            end
            OFSR_WAIT_T: begin
                if (cnt_q == TMR_W'(FILT_CNT - 1)) begin
                    tmr_d = OFSR_ARMED_T;
                end else begin
                    cnt_d = cnt_q + TMR_W'(1);
                end
            end
            default: begin
                tmr_d = OFSR_ARMED_T;
            end
        endcase
        if (cs_rise) begin
            tmr_d = OFSR_WAIT_T;
            cnt_d = '0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmr_q <= OFSR_IDLE_T;
            cnt_q <= '0;
        end else begin
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
        end
    end
    wire armed = (tmr_q == OFSR_ARMED_T);
    // ****************************************************************
    // Pull-down sources and self-test
    // ****************************************************************
    logic [NUM_OUT-1:0] pd_q;
    logic st_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pd_q <= '1;
            st_q <= 1'b0;
        end else begin
            pd_q <= ~(pulldown_dis | {NUM_OUT{sleep_mode}});
            if (self_test_wr) begin
                st_q <= self_test_val;
            end
        end
    end
    assign pulldown_on = pd_q;
    assign self_test_enable = st_q;
    // ****************************************************************
    // Latched fault flags per output
    // ****************************************************************
    logic [NUM_OUT-1:0] ol_q, oc_q, ot_q, sg_q;
    // Output number served by a read index, NUM_OUT when none
    function automatic int idx_out(input logic [3:0] idx);
        if (idx <= IDX_LAMP) begin
            return int'(idx);
        end else if (idx >= IDX_HEATER && idx <= IDX_SPARK_TWO) begin
            return int'(idx) - 1;
        end else begin
            return NUM_OUT;
        end
    endfunction
    function automatic logic [3:0] out_mask(input int n);
        if (n == 4) begin
            return MASK_TACHO;
        end else if (n >= 6) begin
            return MASK_PRE;
        end else begin
            return MASK_FULL;
        end
    endfunction
    wire rd_go = rd_strobe;
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            wire [3:0] m = out_mask(g);
            // Off, source on, filter expired
            wire ol_ev = ol_s2_q[g] & ~out_cmd_on[g] & pd_q[g] & armed;
            wire clr = rd_go && (idx_out(rd_index) == g);
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    ol_q[g] <= 1'b0;
                    oc_q[g] <= 1'b0;
                    ot_q[g] <= 1'b0;
                    sg_q[g] <= 1'b0;
                end else begin
                    // Set wins over read clear
                    ol_q[g] <= m[BIT_OPEN_LOAD] & pd_q[g] & (ol_ev | (ol_q[g] & ~clr));
                    oc_q[g] <= m[BIT_OVERCURRENT] & (oc_s2_q[g] | (oc_q[g] & ~clr));
                    ot_q[g] <= m[BIT_OVERTEMP] & (ot_s2_q[g] | (ot_q[g] & ~clr));
                    sg_q[g] <= m[BIT_SHORT_GND] & (sg_s2_q[g] | (sg_q[g] & ~clr));
                end
            end
        end
    endgenerate
    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire [31:0] sel = idx_out(rd_index);
    wire [3:0] sel_n = sel[3:0];
    wire sel_fault = (sel < NUM_OUT);
    wire [3:0] flags = sel_fault ?
        {ol_q[sel_n], oc_q[sel_n], ot_q[sel_n], sg_q[sel_n]} : 4'h0;
    wire [7:0] fault_byte = {|flags, 3'h0, flags};
    logic [7:0] mux;
    // Status still returned in low supply, unqualified
    always_comb begin
        if (sel_fault) begin
            mux = fault_byte;
        end else if (rd_index == IDX_WATCHDOG) begin
            mux = watchdog_in;
        end else if (rd_index == IDX_SENSOR) begin
            mux = sensor_in;
        end else if (rd_index == IDX_SUPPLY) begin
            mux = supply_in;
        end else if (rd_index == IDX_ON_OFF) begin
            mux = on_off_in;
        end else if (rd_index == IDX_MODEL) begin
            mux = {MODEL_CODE, REV_CODE};
        end else begin
            mux = RESET_BYTE;
        end
    end
    logic [7:0] rd_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_q <= RESET_BYTE;
        end else if (rd_go) begin
            rd_q <= mux;
        end
    end
    assign rd_data = rd_q;
endmodule // ofsr_bank

/* File: verification/ofsr_bank_chk.sv */
// Checker for the fault and status register bank
`timescale 1ns/1ps
module ofsr_bank_chk
    import ofsr_pkg::*;
#(
    parameter int FILT_CNT = FILT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Reads
    input wire logic rd_strobe,
    input wire logic [3:0] rd_index,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] on_off_in,
    // Pull-downs
    input wire logic [NUM_OUT-1:0] pulldown_dis,
    input wire logic sleep_mode,
    input wire logic [NUM_OUT-1:0] pulldown_on
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    spare_bits_a: assert property (rd_strobe && rd_index <= 4'h9 |=> rd_data[6:4] == 3'h0)
        else $error("spare fault bits set");
    pre_bits_a: assert property (rd_strobe && rd_index inside {[4'h7:4'h9]} |=> rd_data[1:0] == 2'h0)
        else $error("predriver spare bits set");
    tacho_bits_a: assert property (rd_strobe && rd_index == 4'h4 |=> !rd_data[0])
        else $error("tacho short bit set");
    gap_zero_a: assert property (rd_strobe && rd_index inside {4'h6, 4'hC} |=> rd_data == 8'h00)
        else $error("unmapped index not zero");
    summary_or_a: assert property (rd_strobe && rd_index <= 4'h9 |=> rd_data[7] == |rd_data[3:0])
        else $error("summary flag wrong");
    model_code_a: assert property (rd_strobe && rd_index == 4'hF |=> rd_data == {MODEL_CODE, REV_CODE})
        else $error("model code wrong");
    ol_gated_a: assert property (rd_strobe && rd_index == 4'h0 && !pulldown_on[0] && !$past(pulldown_on[0])
        |=> !rd_data[3])
        else $error("open load with pull-down off");
    pd_cause_a: assert property ($fell(pulldown_on[0]) |-> $past(pulldown_dis[0]) || $past(sleep_mode))
        else $error("pull-down dropped without cause");
    pd_sleep_a: assert property (sleep_mode |=> pulldown_on == '0)
        else $error("pull-down on in sleep");
    pd_powerup_a: assert property ($rose(rst_n) |-> pulldown_on == '1)
        else $error("pull-down off after reset");
    onoff_read_a: assert property (rd_strobe && rd_index == 4'hE |=> rd_data == $past(on_off_in))
        else $error("on off state wrong");
endmodule // ofsr_bank_chk
bind ofsr_bank ofsr_bank_chk #(.FILT_CNT(FILT_CNT)) chk_i (.core_clk(core_clk), .rst_n(rst_n),
    .rd_strobe(rd_strobe), .rd_index(rd_index), .rd_data(rd_data), .on_off_in(on_off_in),
    .pulldown_dis(pulldown_dis), .sleep_mode(sleep_mode), .pulldown_on(pulldown_on));

/* File: verification/ofsr_mcu.sv */
// Microcontroller chip-select frame model
`timescale 1ns/1ps
module ofsr_mcu (
    // Clock
    input wire logic core_clk,
    // Frame request
    input wire logic frame_go,
    // Serial select
    output logic chip_select_n
);
    initial chip_select_n = 1'b1;
    // Eight-cycle frame; its rising edge restarts the filter
    always @(negedge core_clk) begin
        if (frame_go && chip_select_n) begin
            chip_select_n <= 1'b0;
            repeat (8) @(negedge core_clk);
            chip_select_n <= 1'b1;
        end
    end
endmodule // ofsr_mcu

/* File: verification/test_ofsr_bank.sv */
// Testbench for the fault and status register bank
`timescale 1ns/1ps
module test_ofsr_bank import ofsr_pkg::*;;
    localparam int FILT = 20;
    logic clk, rst_n, cs_n, stb, slp, st_wr, st_val, st_en, go;
    logic [3:0] idx;
    logic [7:0] rdat;
    logic [NUM_OUT-1:0] on, dis, pd, ol, oc, ot, sg;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] xr [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'hA5, 8'h3C, 0, 8'h81, 8'h42,
        {MODEL_CODE, REV_CODE}};
    logic [7:0] fx [10] = '{8'h87, 8'h87, 8'h87, 8'h87, 8'h86, 8'h87, 8'h00, 8'h84, 8'h84, 8'h84};
    ofsr_bank #(.FILT_CNT(FILT)) uut (.core_clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .rd_strobe(stb), .rd_index(idx), .rd_data(rdat), .out_cmd_on(on), .pulldown_dis(dis),
        .sleep_mode(slp), .self_test_wr(st_wr), .self_test_val(st_val), .self_test_enable(st_en),
        .pulldown_on(pd), .open_load_cmp(ol), .overcurrent_in(oc), .overtemp_in(ot),
        .short_ground_in(sg), .watchdog_in(8'hA5), .sensor_in(8'h3C), .supply_in(8'h81),
        .on_off_in(8'h42));
    ofsr_mcu mcu_i (.core_clk(clk), .frame_go(go), .chip_select_n(cs_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [3:0] i, input logic [7:0] exp);
        @(negedge clk);
        stb = 1'b1;
        idx = i;
        @(negedge clk);
        stb = 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", i), {1'b0, rdat}, {1'b0, exp});
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {rst_n, stb, idx, slp, st_wr, st_val, go} = '0;
        {on, dis, ol, oc, ot, sg} = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk("pulldowns", pd, 9'h1FF);
        for (int i = 0; i < 16; i++) begin
            rd(i[3:0], xr[i]);
        end
        {oc, ot, sg} = '1;
        repeat (4) @(negedge clk);
        {oc, ot, sg} = '0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], fx[i]);
        end
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], 8'h00);
        end
        on[1] = 1'b1;
        dis[2] = 1'b1;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        repeat (14) @(negedge clk);
        ol = 9'h007;
        repeat (4) @(negedge clk);
        rd(4'h0, 8'h00);
        repeat (FILT) @(negedge clk);
        ol = '0;
        repeat (4) @(negedge clk);
        rd(4'h0, 8'h88);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h00);
        chk("pulldowns", pd, 9'h1FB);
        st_val = 1'b1;
        st_wr = 1'b1;
        @(negedge clk);
        st_wr = 1'b0;
        @(negedge clk);
        chk("self test", {8'h00, st_en}, 9'h001);
        slp = 1'b1;
        repeat (2) @(negedge clk);
        chk("sleep pulldowns", pd, 9'h000);
        rd(4'h0, 8'h00);
        complete_run();
    end
endmodule // test_ofsr_bank
